// File: rtl/bsp_spi_port.sv
// Purpose: Clock-stop serial port, master or slave, inverted clock polarity.
// Assumes: Pins are synchronous to mclk; one unit of 2H is one mclk cycle.
// Notes: Sixteen-bit words, msb first.
// Contract
// - Slave mode forces sample clock source and divider to one.
// - Master clock period is (1 + divider) times 2H.
// - High phase is half period, or (div/2+1)*2H for even divider.
// - Low phase is half period, or (div/2)*2H for even divider.
// - Sync polarity bits are one; master select output is active low.
// - Slave inverts the incoming active-low select before use.
// - Master: transmit clock and sync driven, receive ones inputs.
// - Slave: all clock and sync direction bits zero.
// - Master drives select low before the first clock edge.
// - Code 10b: sample on rising edge, change after falling edge.
// - Code 11b: sample on falling edge, change after rising edge.
// - Code 10b master: select leads by high phase, trails by one period.
// - Code 11b master: select leads by one period, trails by high phase.
// - Slave drives first bit as soon as select falls.
// - Slave releases data output when select rises.
// - Code 10b master releases data one high phase after last rise.
`timescale 1ns/10ps
`include "bsp_spi_consts.svh"
module bsp_spi_port
	import bsp_spi_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic masterMode,
	input wire logic [1:0] clock_stop_code,
	input wire logic [7:0] sample_clock_divider,
	input wire logic start,
	input wire logic [15:0] txWord,
	output logic [15:0] rxWord,
	output logic rxValid,
	output logic busy,
	output logic tx_clock_direction,
	output logic rx_clock_direction,
	output logic tx_sync_direction,
	output logic rx_sync_direction,
	output logic tx_sync_polarity,
	output logic rx_sync_polarity,
	output logic sample_clock_source_sel,
	output logic [7:0] effDivider,
	input wire logic serial_tx_clock_pin_i,
	output logic serial_tx_clock_pin_o,
	output logic serial_tx_clock_pin_oe,
	input wire logic tx_frame_sync_pin_i,
	output logic tx_frame_sync_pin_o,
	output logic tx_frame_sync_pin_oe,
	input wire logic rx_frame_sync_pin_i,
	input wire logic serial_rx_data_pin,
	output logic serial_tx_data_pin_o,
	output logic serial_tx_data_pin_oe
);
	bsp_clk_if clkIf();
	bsp_tick_gen uTick (
		.mclk(mclk),
		.rst_n(rst_n),
		.clkIf(clkIf.gen)
	);

	// High and low phase lengths in 2H units for a given divider.
	function automatic logic [8:0] phaseLen(input logic [7:0] d, input logic high);
		logic [8:0] per;
		per = {1'b0, d} + 9'h001;
		if (d == 8'h00 || d[0]) begin
			phaseLen = per >> 1;
		end else begin
			phaseLen = high ? ({1'b0, d} >> 1) + 9'h001 : ({1'b0, d} >> 1);
		end
	endfunction : phaseLen

	// Mode bits follow the role; slave pins the divider to one.
	always_comb begin
		effDivider = masterMode ? sample_clock_divider : `BSP_SLAVE_DIVIDER;
		sample_clock_source_sel = masterMode ? 1'b1 : `BSP_SLAVE_SOURCE;
		tx_clock_direction = masterMode;
		tx_sync_direction = masterMode;
		rx_clock_direction = 1'b0;
		rx_sync_direction = 1'b0;
		tx_sync_polarity = `BSP_SYNC_POLARITY;
		rx_sync_polarity = `BSP_SYNC_POLARITY;
	end

	logic isLate;
	logic [8:0] hiLen;
	logic [8:0] loLen;
	logic [8:0] perLen;
	assign isLate = (clock_stop_code == `BSP_STOP_CODE_LATE);
	assign hiLen = phaseLen(effDivider, 1'b1);
	assign loLen = phaseLen(effDivider, 1'b0);
	assign perLen = {1'b0, effDivider} + 9'h001;

	// Master sequencer: lead, sixteen clock cycles, tail.
	bsp_state_e state_reg, state_next;
	logic [8:0] cnt_reg, cnt_next;
	logic [4:0] bits_reg, bits_next;
	logic sck_reg, sck_next;
	logic [15:0] txSh_reg, txSh_next;
	logic [15:0] rxSh_reg, rxSh_next;
	logic [15:0] rxWord_next;
	logic rxValid_next;
	logic dOut_reg, dOut_next;
	logic dEn_reg, dEn_next;
	logic sel_reg, sel_next;
	logic sckIn_reg, sckIn_next;
	logic slvSel_reg, slvSel_next;
	logic slvSel;
	logic tick;

	assign tick = clkIf.tick;
	assign clkIf.run = 1'b1;
	// Slave select arrives active low on both sync pins; invert before use.
	assign slvSel = ~tx_frame_sync_pin_i & ~rx_frame_sync_pin_i;

	always_comb begin
		logic capEdge;
		logic rise;
		logic fall;
		logic sRise;
		logic sFall;
		capEdge = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		sRise = 1'b0;
		sFall = 1'b0;
		state_next = state_reg;
		cnt_next = cnt_reg;
		bits_next = bits_reg;
		sck_next = sck_reg;
		txSh_next = txSh_reg;
		rxSh_next = rxSh_reg;
		rxWord_next = rxWord;
		rxValid_next = 1'b0;
		dOut_next = dOut_reg;
		dEn_next = dEn_reg;
		sel_next = sel_reg;
		sckIn_next = serial_tx_clock_pin_i;
		slvSel_next = slvSel;
		if (masterMode) begin
			unique case (state_reg)
				BSP_IDLE: begin
					sck_next = 1'b1;
					if (start) begin
						// Select and first bit go out together, ahead of any edge.
						state_next = BSP_LEAD;
						sel_next = 1'b1;
						txSh_next = {txWord[14:0], 1'b0};
						dOut_next = txWord[15];
						dEn_next = 1'b1;
						cnt_next = isLate ? hiLen : perLen;
						bits_next = 5'h00;
					end
				end
				BSP_LEAD: begin
					if (tick) begin
						cnt_next = cnt_reg - 9'h001;
						if (cnt_reg == 9'h001) begin
							state_next = BSP_SHIFT;
							sck_next = 1'b0;
							fall = 1'b1;
							cnt_next = loLen;
						end
					end
					// The first falling edge already carries a sample for code 11b.
					capEdge = isLate ? 1'b0 : fall;
				end
				BSP_SHIFT: begin
					if (tick) begin
						cnt_next = cnt_reg - 9'h001;
						if (cnt_reg == 9'h001) begin
							sck_next = ~sck_reg;
							rise = ~sck_reg;
							fall = sck_reg;
							cnt_next = sck_reg ? loLen : hiLen;
						end
					end
					// Code 10b samples on rise, 11b on fall; shift on the other edge.
					capEdge = isLate ? rise : fall;
					if (rise) begin
						bits_next = bits_reg + 5'h01;
					end
					if (rise && bits_reg == `BSP_WORD_MSB) begin
						state_next = BSP_TAIL;
						cnt_next = isLate ? perLen : hiLen;
					end else if (isLate ? fall : rise) begin
						// Code 11b changes after every rise but the last one.
						dOut_next = txSh_reg[15];
						txSh_next = {txSh_reg[14:0], 1'b0};
					end
				end
				BSP_TAIL: begin
					if (tick) begin
						cnt_next = cnt_reg - 9'h001;
						if (isLate && cnt_reg == perLen - hiLen + 9'h001) begin
							dEn_next = 1'b0;
						end
						if (cnt_reg == 9'h001) begin
							state_next = BSP_IDLE;
							sel_next = 1'b0;
							dEn_next = 1'b0;
							rxWord_next = rxSh_reg;
							rxValid_next = 1'b1;
						end
					end
				end
				default: begin
					state_next = BSP_IDLE;
				end
			endcase
		end else begin
			// Slave: clock and select come from outside.
			state_next = BSP_IDLE;
			sel_next = 1'b0;
			sRise = serial_tx_clock_pin_i & ~sckIn_reg;
			sFall = ~serial_tx_clock_pin_i & sckIn_reg;
			capEdge = slvSel_reg && (isLate ? sRise : sFall);
			if (slvSel && !slvSel_reg) begin
				dOut_next = txWord[15];
				txSh_next = {txWord[14:0], 1'b0};
				dEn_next = 1'b1;
				bits_next = 5'h00;
			end else if (!slvSel && slvSel_reg) begin
				dEn_next = 1'b0;
				rxWord_next = rxSh_reg;
				rxValid_next = 1'b1;
			end else if (slvSel_reg && (isLate ? sFall : sRise) && bits_reg != 5'h00) begin
				dOut_next = txSh_reg[15];
				txSh_next = {txSh_reg[14:0], 1'b0};
			end
			if (capEdge) begin
				bits_next = bits_reg + 5'h01;
			end
		end
		if (capEdge) begin
			rxSh_next = {rxSh_reg[14:0], serial_rx_data_pin};
		end
	end

	// All state of the port registers here.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= BSP_IDLE;
			cnt_reg <= 9'h000;
			bits_reg <= 5'h00;
			sck_reg <= 1'b1;
			txSh_reg <= 16'h0000;
			rxSh_reg <= 16'h0000;
			rxWord <= 16'h0000;
			rxValid <= 1'b0;
			dOut_reg <= 1'b0;
			dEn_reg <= 1'b0;
			sel_reg <= 1'b0;
			sckIn_reg <= 1'b1;
			slvSel_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bits_reg <= bits_next;
			sck_reg <= sck_next;
			txSh_reg <= txSh_next;
			rxSh_reg <= rxSh_next;
			rxWord <= rxWord_next;
			rxValid <= rxValid_next;
			dOut_reg <= dOut_next;
			dEn_reg <= dEn_next;
			sel_reg <= sel_next;
			sckIn_reg <= sckIn_next;
			slvSel_reg <= slvSel_next;
		end
	end

	// Pin drive; the clock idles high because polarity is inverted.
	assign busy = (state_reg != BSP_IDLE) | slvSel_reg;
	assign serial_tx_clock_pin_o = sck_reg;
	assign serial_tx_clock_pin_oe = masterMode;
	assign tx_frame_sync_pin_o = ~sel_reg;
	assign tx_frame_sync_pin_oe = masterMode;
	assign serial_tx_data_pin_o = dOut_reg;
	assign serial_tx_data_pin_oe = dEn_reg;

	// Select must lead the first clock edge and the clock stays idle outside a word.
	chk_select_before_clock: assert property (@(posedge mclk) disable iff (!rst_n)
		masterMode && $fell(sck_reg) && $past(state_reg) == BSP_LEAD
		|-> sel_reg && $past(sel_reg))
		else $error("clock moved without select");
	chk_idle_clock_high: assert property (@(posedge mclk) disable iff (!rst_n)
		masterMode && state_reg == BSP_IDLE |-> sck_reg)
		else $error("clock not idle high");
	chk_first_bit_drive: assert property (@(posedge mclk) disable iff (!rst_n)
		masterMode && state_reg == BSP_IDLE && start |=> dEn_reg && sel_reg)
		else $error("first bit not driven");
	chk_slave_release: assert property (@(posedge mclk) disable iff (!rst_n)
		!masterMode && !slvSel && slvSel_reg |=> !dEn_reg)
		else $error("slave did not release");
	chk_slave_drive: assert property (@(posedge mclk) disable iff (!rst_n)
		!masterMode && slvSel && !slvSel_reg |=> dEn_reg)
		else $error("slave did not drive");
	chk_slave_divider: assert property (@(posedge mclk) disable iff (!rst_n)
		!masterMode |-> effDivider == 8'h01 && !tx_clock_direction)
		else $error("slave divider wrong");
	// The select pin is low exactly while the sequencer is away from idle.
	chk_sync_inverted: assert property (@(posedge mclk) disable iff (!rst_n)
		masterMode |-> tx_frame_sync_pin_o == (state_reg == BSP_IDLE))
		else $error("select not active low");
	// Code 10b must have released data at least a cycle before select rises.
	chk_late_release: assert property (@(posedge mclk) disable iff (!rst_n)
		masterMode && isLate && $changed(state_reg) && state_reg == BSP_IDLE
		|-> !dEn_reg && !$past(dEn_reg))
		else $error("data not released");
endmodule : bsp_spi_port

// File: shared/bsp_spi_consts.svh
// Purpose: Constants for the clock-stop serial port block.
// Assumes: Included by bare name from design files.
// Notes: Field codes and timing counts only; no logic here.
`ifndef BSP_SPI_CONSTS_SVH
`define BSP_SPI_CONSTS_SVH
`define BSP_STOP_CODE_LATE 2'h2
`define BSP_STOP_CODE_EARLY 2'h3
`define BSP_SLAVE_DIVIDER 8'h01
`define BSP_SLAVE_SOURCE 1'h1
`define BSP_SYNC_POLARITY 1'h1
`define BSP_WORD_BITS 5'h10
`define BSP_WORD_MSB 4'hf
`endif

// File: shared/bsp_spi_pkg.sv
// Purpose: Types for the clock-stop serial port block.
// Assumes: Nothing beyond the constants header.
// Notes: Phase-generator states are one-hot.
package bsp_spi_pkg;
	typedef enum logic [3:0] {
		BSP_IDLE = 4'h1,
		BSP_LEAD = 4'h2,
		BSP_SHIFT = 4'h4,
		BSP_TAIL = 4'h8
	} bsp_state_e;
	typedef logic [7:0] bsp_div_t;
endpackage : bsp_spi_pkg

// File: shared/bsp_clk_if.sv
// Purpose: Carries the sample-rate clock enable between the divider and the port.
// Assumes: One clock domain.
// Notes: The tick is a one-cycle pulse each 2H.
`timescale 1ns/10ps
interface bsp_clk_if;
	logic tick;
	logic run;
	modport gen (output tick, input run);
	modport use_side (input tick, output run);
endinterface : bsp_clk_if

// File: rtl/bsp_tick_gen.sv
// Purpose: Produces the sample-rate enable, one pulse every CPU cycle.
// Assumes: mclk is the CPU clock, so one mclk period is 2H.
// Notes: A tick each cycle marks one 2H unit of the serial clock.
`timescale 1ns/10ps
module bsp_tick_gen (
	input wire logic mclk,
	input wire logic rst_n,
	bsp_clk_if.gen clkIf
);
	// The CPU clock period is 2H, so every run cycle is one unit.
	logic tick_reg;
	logic tick_next;
	always_comb begin
		tick_next = clkIf.run;
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= tick_next;
		end
	end
	assign clkIf.tick = tick_reg;
endmodule : bsp_tick_gen

// File: test/bsp_spi_partner.sv
// Purpose: Far-side SPI device, slave or master, idle-high clock.
// Assumes: Select is active low; master period is 16 mclk cycles.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/10ps
module bsp_spi_partner (
	input wire logic mclk,
	input wire logic drvMaster,
	input wire logic [1:0] stopCode,
	input wire logic [15:0] sendWord,
	input wire logic clkIn,
	input wire logic selInN,
	input wire logic dataIn,
	output logic clkOut,
	output logic selOutN,
	output logic dataOut,
	output logic [15:0] gotWord
);
	logic [15:0] sh;
	int nSamp;
	// Idle levels before any word.
	initial begin
		clkOut = 1'h1;
		selOutN = 1'h1;
		dataOut = 1'h0;
		gotWord = 16'h0;
	end
	// As slave, the first bit is shown as soon as select falls.
	always @(negedge selInN) if (!drvMaster) begin
		sh = sendWord;
		dataOut = sendWord[15];
		nSamp = 0;
	end
	// No change before the first sample, so the first bit survives the lead edge.
	always @(clkIn) if (!drvMaster && !selInN) begin
		if (clkIn == (stopCode == 2'h2)) begin
			gotWord = {gotWord[14:0], dataIn};
			nSamp++;
		end else if (nSamp > 0) begin
			sh = {sh[14:0], 1'h0};
			dataOut = sh[15];
		end
	end
	// Inverting on release keeps a stale bit from passing for data.
	always @(posedge selInN) dataOut = ~dataOut;
	// As master, one word with a 32H period and select set well ahead.
	task automatic run_master();
		int i;
		@(posedge mclk);
		selOutN <= 1'h0;
		dataOut <= sendWord[15];
		repeat (16) @(posedge mclk);
		for (i = 0; i < 16; i++) begin
			clkOut <= 1'h0;
			if (stopCode == 2'h3) gotWord <= {gotWord[14:0], dataIn};
			else if (i > 0) dataOut <= sendWord[15-i];
			repeat (8) @(posedge mclk);
			clkOut <= 1'h1;
			if (stopCode == 2'h2) gotWord <= {gotWord[14:0], dataIn};
			else if (i < 15) dataOut <= sendWord[14-i];
			repeat (8) @(posedge mclk);
		end
		repeat (16) @(posedge mclk);
		selOutN <= 1'h1;
	endtask : run_master
endmodule : bsp_spi_partner

// File: test/serial_port_spi_clock_stop_tb_top.sv
// Purpose: Self-checking bench for the clock-stop serial port.
// Assumes: One mclk period is one 2H unit.
// Notes: Edge times are logged in cycles at the falling mclk edge.
`timescale 1ns/10ps
module serial_port_spi_clock_stop_tb_top;
	logic mclk, rst_n, masterMode, start, junk, rxValid, busy;
	logic tcd, rcd, tsd, rsd, tsp, rsp, scs, clkO, clkOe, fsO, fsOe, datO, datOe;
	logic pClk, pSel, pDat;
	logic [1:0] code;
	logic [7:0] div, effDivider;
	logic [15:0] txWord, rxWord, sendWord, gotWord, rxCap;
	int bad_count = 0;
	int compares = 0;
	int fall[$], rise[$];
	int tSel, tSelHi, tOff;
	// Wire levels resolved from the port's enables.
	wire clkW = clkOe ? clkO : pClk;
	wire selW = fsOe ? fsO : pSel;
	wire datW = datOe ? datO : junk;
	bsp_spi_port uut (.mclk(mclk), .rst_n(rst_n), .masterMode(masterMode),
		.clock_stop_code(code), .sample_clock_divider(div), .start(start),
		.txWord(txWord), .rxWord(rxWord), .rxValid(rxValid), .busy(busy),
		.tx_clock_direction(tcd), .rx_clock_direction(rcd), .tx_sync_direction(tsd),
		.rx_sync_direction(rsd), .tx_sync_polarity(tsp), .rx_sync_polarity(rsp),
		.sample_clock_source_sel(scs), .effDivider(effDivider),
		.serial_tx_clock_pin_i(clkW), .serial_tx_clock_pin_o(clkO),
		.serial_tx_clock_pin_oe(clkOe), .tx_frame_sync_pin_i(selW),
		.tx_frame_sync_pin_o(fsO), .tx_frame_sync_pin_oe(fsOe),
		.rx_frame_sync_pin_i(pSel), .serial_rx_data_pin(pDat),
		.serial_tx_data_pin_o(datO), .serial_tx_data_pin_oe(datOe));
	bsp_spi_partner partner (.mclk(mclk), .drvMaster(~masterMode), .stopCode(code),
		.sendWord(sendWord), .clkIn(clkW), .selInN(selW), .dataIn(datW),
		.clkOut(pClk), .selOutN(pSel), .dataOut(pDat), .gotWord(gotWord));
	// Clock, and a line pattern that changes every cycle.
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) junk <= ~junk;
	task automatic chkW(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chkW
	task automatic chkN(input int got, input int exp);
		chkW(16'(got), 16'(exp));
	endtask : chkN
	task automatic results();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// Logs one word on the wire; a second start mid-word must be ignored.
	task automatic watch(input int len, input logic [15:0] w);
		logic pc;
		int n;
		fall.delete();
		rise.delete();
		tSel = -1;
		tSelHi = -1;
		tOff = -1;
		pc = 1'h1;
		for (n = 0; n < len; n++) begin
			@(posedge mclk);
			start <= masterMode && (n == 0 || n == 6);
			txWord <= (n < 6) ? w : ~w;
			@(negedge mclk);
			if (rxValid === 1'h1) rxCap = rxWord;
			if (selW === 1'h0 && tSel < 0) tSel = n;
			if (tSel >= 0 && n == tSel + (masterMode ? 0 : 2)) begin
				chkW(datOe, 1'h1);
				chkW(datO, w[15]);
				chkW(busy, 1'h1);
			end
			if (selW === 1'h1 && tSel >= 0 && tSelHi < 0) tSelHi = n;
			if (datOe === 1'h0 && tSel >= 0 && n > tSel + 2 && tOff < 0) tOff = n;
			if (clkW !== pc && clkW === 1'h0) fall.push_back(n);
			if (clkW !== pc && clkW === 1'h1) rise.push_back(n);
			pc = clkW;
		end
	endtask : watch
	task automatic master_word(input logic [1:0] c, input logic [7:0] d, input logic [15:0] w);
		int t, hi, i;
		t = 1 + d;
		hi = d[0] ? t / 2 : d / 2 + 1;
		@(posedge mclk);
		masterMode <= 1'h1;
		code <= c;
		div <= d;
		sendWord <= {w[7:0], w[15:8]};
		watch(20 * t + 40, w);
		chkW({tcd, tsd, rcd, rsd, tsp, rsp}, 6'h33);
		chkW(busy, 1'h0);
		chkN(fall.size(), 16);
		chkN(fall[0] - tSel, (c == 2'h2) ? hi : t);
		for (i = 0; i < 16; i++) begin
			chkN(rise[i] - fall[i], t - hi);
			if (i < 15) chkN(fall[i+1] - rise[i], hi);
		end
		chkN(tSelHi - rise[15], (c == 2'h2) ? t : hi);
		if (c == 2'h2) chkN(tOff - rise[15], hi);
		chkW(gotWord, w);
		chkW(rxCap, {w[7:0], w[15:8]});
	endtask : master_word
	task automatic slave_word(input logic [1:0] c, input logic [15:0] w);
		@(posedge mclk);
		masterMode <= 1'h0;
		code <= c;
		sendWord <= ~w;
		txWord <= w;
		@(posedge mclk);
		chkW({scs, effDivider}, 9'h101);
		chkW({tcd, tsd, rcd, rsd, tsp, rsp}, 6'h03);
		fork
			partner.run_master();
			watch(340, w);
		join
		chkN(fall.size(), 16);
		chkW(gotWord, w);
		chkW(rxCap, ~w);
		chkN(tOff >= tSelHi && tOff <= tSelHi + 3, 1);
	endtask : slave_word
	// Reset, then every code with odd and even dividers, then both slave codes.
	initial begin
		rst_n = 1'h0;
		masterMode = 1'h1;
		start = 1'h0;
		junk = 1'h0;
		code = 2'h2;
		div = 8'h03;
		txWord = 16'h0;
		sendWord = 16'h0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chkW({clkO, fsO, datOe, rxValid}, 4'hc);
		@(posedge mclk);
		rst_n <= 1'h1;
		for (int c = 2; c < 4; c++) begin
			for (int d = 1; d < 5; d++) master_word(2'(c), 8'(d), 16'h9c35 ^ 16'(d * 16'h1111));
		end
		slave_word(2'h2, 16'h5a0f);
		slave_word(2'h3, 16'hc3e1);
		results();
	end
	// Cuts a hang short well past the expected run of about 1600 cycles.
	initial begin
		#200000;
		bad_count++;
		results();
	end
endmodule : serial_port_spi_clock_stop_tb_top
